/* File: design/mca_ctl_decode.sv */
/*
 * decodes the control word into per-space activity and buffer lengths.
 * assumes start and end are inclusive byte addresses.
 */
`timescale 1ns/1ns
module mca_ctl_decode
	import mca_pkg::*;
(
	// configuration
	input  wire mca_ptr_t    ctrl_i,
	input  wire mca_ptr_t    xs_i,
	input  wire mca_ptr_t    xe_i,
	input  wire mca_ptr_t    ys_i,
	input  wire mca_ptr_t    ye_i,
	// decoded
	output logic             x_act_o,
	output logic             y_act_o,
	output mca_sel_t         x_sel_o,
	output mca_sel_t         y_sel_o,
	output logic [16:0]      x_len_o,
	output logic [16:0]      y_len_o
);
	import mca_pkg::*;

	always_comb begin
		x_sel_o = ctrl_i[CTL_XSEL_LSB +: SEL_W];
		y_sel_o = ctrl_i[CTL_YSEL_LSB +: SEL_W];
		x_act_o = ctrl_i[CTL_XEN_BIT] && (x_sel_o != SEL_OFF);
		y_act_o = ctrl_i[CTL_YEN_BIT] && (y_sel_o != SEL_OFF);
		// length in words from the boundary difference, capped at MAX_LEN_WORDS
		x_len_o = 17'(({1'b0, xe_i} - {1'b0, xs_i} + 17'h00001) >> 1);
		y_len_o = 17'(({1'b0, ye_i} - {1'b0, ys_i} + 17'h00001) >> 1);
		if (x_len_o > MAX_LEN_WORDS) begin
			x_len_o = MAX_LEN_WORDS;
		end
		if (y_len_o > MAX_LEN_WORDS) begin
			y_len_o = MAX_LEN_WORDS;
		end
	end
endmodule

/* File: design/mca_top.sv */
/*
 * circular addressing extension of the address generators: wishbone
 * register file, control decode and three wrap calculators (x read,
 * x write, y). assumes the core presents one pointer update per
 * generator as a one-cycle valid with the working register index.
 */
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ns
module mca_top
	import mca_pkg::*;
(
	// clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [mca_pkg::ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	// generator requests, index 0 x read, 1 x write, 2 y
	input  wire logic [mca_pkg::NUM_AGU-1:0] agu_valid_i,
	input  wire logic [mca_pkg::NUM_AGU-1:0][mca_pkg::SEL_W-1:0] agu_wreg_i,
	input  wire logic [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] agu_ptr_i,
	input  wire logic [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] agu_step_i,
	// generator answers
	output logic      [mca_pkg::NUM_AGU-1:0] agu_done_o,
	output logic      [mca_pkg::NUM_AGU-1:0] agu_wrapped_o,
	output logic      [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] agu_ptr_o,
	// decoded activity for the core
	output logic                             x_active_o,
	output logic                             y_active_o
);
	import mca_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		mca_bus_st_t                         bus;
		logic [31:0]                         rdata;
		mca_ptr_t                            ctrl;
		mca_ptr_t                            xs;
		mca_ptr_t                            xe;
		mca_ptr_t                            ys;
		mca_ptr_t                            ye;
		logic [1:0]                          wrap_flag;
		logic [NUM_AGU-1:0]                  done;
		logic [NUM_AGU-1:0]                  wrapped;
		logic [NUM_AGU-1:0][PTR_W-1:0]       ptr;
		logic                                x_act;
		logic                                y_act;
	} mca_top_state_t;

	mca_top_state_t r;
	mca_top_state_t next_r;

	logic               x_act;
	logic               y_act;
	mca_sel_t           x_sel;
	mca_sel_t           y_sel;
	logic [16:0]        x_len;
	logic [16:0]        y_len;
	logic               req;
	logic               wr;
	logic [NUM_AGU-1:0] calc_wrapped;
	logic [NUM_AGU-1:0][PTR_W-1:0] calc_ptr;

	////////////////////////////////////////////////////////////////////////
	// control decode

	mca_ctl_decode u_dec (
		.ctrl_i  (r.ctrl),
		.xs_i    (r.xs),
		.xe_i    (r.xe),
		.ys_i    (r.ys),
		.ye_i    (r.ye),
		.x_act_o (x_act),
		.y_act_o (y_act),
		.x_sel_o (x_sel),
		.y_sel_o (y_sel),
		.x_len_o (x_len),
		.y_len_o (y_len)
	);

	////////////////////////////////////////////////////////////////////////
	// wrap calculators, the x pair shares the x buffer

	for (genvar g = 0; g < NUM_AGU; g++) begin : g_agu
		mca_agu_if ag ();
		localparam bit IS_Y = (g == AGU_Y);

		// only the y generator forces its pointers to even addresses
		assign ag.active    = IS_Y ? y_act : x_act;
		assign ag.sel       = IS_Y ? y_sel : x_sel;
		assign ag.start     = IS_Y ? r.ys : r.xs;
		assign ag.stop      = IS_Y ? r.ye : r.xe;
		assign ag.word_only = IS_Y;
		assign ag.valid     = agu_valid_i[g];
		assign ag.wreg      = agu_wreg_i[g];
		assign ag.ptr       = agu_ptr_i[g];
		assign ag.step      = agu_step_i[g];
		assign calc_ptr[g]     = ag.next_ptr;
		assign calc_wrapped[g] = ag.wrapped;

		mca_wrap u_wrap (
			.a (ag)
		);
	end

	////////////////////////////////////////////////////////////////////////
	// byte lane merge for the 16-bit registers

	function automatic mca_ptr_t merge(input mca_ptr_t old_v,
		input logic [31:0] d, input logic [3:0] be);
		mca_ptr_t v;
		v = old_v;
		if (be[0]) begin
			v[7:0] = d[7:0];
		end
		if (be[1]) begin
			v[15:8] = d[15:8];
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	assign req = wb_cyc_i && wb_stb_i;
	assign wr  = req && wb_we_i && (r.bus == BUS_IDLE);

	always_comb begin
		next_r = r;

		// generator answers are registered one cycle after the request
		next_r.done    = agu_valid_i;
		next_r.wrapped = calc_wrapped & agu_valid_i;
		for (int i = 0; i < NUM_AGU; i++) begin
			if (agu_valid_i[i]) begin
				next_r.ptr[i] = calc_ptr[i];
			end
		end
		next_r.x_act = x_act;
		next_r.y_act = y_act;

		// bus handshake: one ack per request, then a forced idle cycle
		case (r.bus)
			BUS_IDLE: begin
				if (req) begin
					next_r.bus = BUS_ACK;
				end
			end
			BUS_ACK: begin
				next_r.bus = BUS_IDLE;
			end
			default: begin
				next_r.bus = BUS_IDLE;
			end
		endcase

		// register writes
		if (wr) begin
			if (wb_adr_i == OFS_CTRL) begin
				next_r.ctrl = merge(r.ctrl, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == OFS_XSTART) begin
				next_r.xs = merge(r.xs, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == OFS_XEND) begin
				next_r.xe = merge(r.xe, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == OFS_YSTART) begin
				next_r.ys = merge(r.ys, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == OFS_YEND) begin
				next_r.ye = merge(r.ye, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == OFS_STATUS && wb_sel_i[0]) begin
				// write one to clear
				next_r.wrap_flag = r.wrap_flag &
					~wb_dat_i[STAT_YWRAP:STAT_XWRAP];
			end
		end

		// a wrap in the clearing cycle still sets its flag
		if ((agu_valid_i[AGU_XR] && calc_wrapped[AGU_XR]) ||
			(agu_valid_i[AGU_XW] && calc_wrapped[AGU_XW])) begin
			next_r.wrap_flag[STAT_XWRAP] = 1'b1;
		end
		if (agu_valid_i[AGU_Y] && calc_wrapped[AGU_Y]) begin
			next_r.wrap_flag[STAT_YWRAP] = 1'b1;
		end

		// read data, unmapped addresses answer zero
		next_r.rdata = 32'h00000000;
		if (req && r.bus == BUS_IDLE && !wb_we_i) begin
			if (wb_adr_i == OFS_CTRL) begin
				next_r.rdata[PTR_W-1:0] = r.ctrl;
			end else if (wb_adr_i == OFS_XSTART) begin
				next_r.rdata[PTR_W-1:0] = r.xs;
			end else if (wb_adr_i == OFS_XEND) begin
				next_r.rdata[PTR_W-1:0] = r.xe;
			end else if (wb_adr_i == OFS_YSTART) begin
				next_r.rdata[PTR_W-1:0] = r.ys;
			end else if (wb_adr_i == OFS_YEND) begin
				next_r.rdata[PTR_W-1:0] = r.ye;
			end else if (wb_adr_i == OFS_STATUS) begin
				next_r.rdata[STAT_YWRAP:STAT_XWRAP] = r.wrap_flag;
				next_r.rdata[STAT_XACT] = x_act;
				next_r.rdata[STAT_YACT] = y_act;
			end else if (wb_adr_i == OFS_XLEN) begin
				next_r.rdata[16:0] = x_len;
			end else if (wb_adr_i == OFS_YLEN) begin
				next_r.rdata[16:0] = y_len;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r           <= '0;
			r.bus       <= BUS_IDLE;
			r.ctrl      <= CTRL_RESET;
			r.xs        <= BOUND_RESET;
			r.xe        <= BOUND_RESET;
			r.ys        <= BOUND_RESET;
			r.ye        <= BOUND_RESET;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_ack_o      = (r.bus == BUS_ACK);
	assign wb_dat_o      = r.rdata;
	assign agu_done_o    = r.done;
	assign agu_wrapped_o = r.wrapped;
	assign agu_ptr_o     = r.ptr;
	assign x_active_o    = r.x_act;
	assign y_active_o    = r.y_act;

endmodule

/* File: design/mca_wrap.sv */
/*
 * one wrap calculator: adds the step and folds the pointer back into the
 * buffer. assumes step is a two's complement byte offset.
 */
`timescale 1ns/1ns
module mca_wrap
	import mca_pkg::*;
(
	// request and answer
	mca_agu_if.calc a
);
	import mca_pkg::*;

	logic [16:0] up_sum;
	logic [16:0] mag;
	logic        hit;
	logic        neg;
	mca_ptr_t    sum;

	always_comb begin
		hit = a.active && a.valid && (a.wreg == a.sel);
		neg = a.step[PTR_W-1];
		mag = 17'({1'b0, ~a.step} + 17'h00001);
		up_sum = {1'b0, a.ptr} + {1'b0, a.step};
		sum = a.ptr + a.step;
		a.wrapped = 1'b0;
		a.next_ptr = sum;
		// both boundaries are checked so buffers of any length run both ways
		if (hit && !neg && a.ptr <= a.stop && up_sum > {1'b0, a.stop}) begin
			a.next_ptr = a.start;
			a.wrapped = 1'b1;
		end else if (hit && neg && a.ptr >= a.start &&
			({1'b0, a.ptr} < mag || sum < a.start)) begin
			a.next_ptr = a.stop;
			a.wrapped = 1'b1;
		end
		if (a.word_only) begin
			a.next_ptr[0] = 1'b0;
		end
	end
endmodule

/* File: pkg/mca_agu_if.sv */
/*
 * carrier between the top and one wrap calculator.
 * assumes the top fills configuration and request, the calculator answers.
 */
`timescale 1ns/1ns
interface mca_agu_if;
	import mca_pkg::*;
	logic     active;
	logic     word_only;
	mca_sel_t sel;
	mca_ptr_t start;
	mca_ptr_t stop;
	logic     valid;
	mca_sel_t wreg;
	mca_ptr_t ptr;
	mca_ptr_t step;
	mca_ptr_t next_ptr;
	logic     wrapped;

	modport ctl (output active, word_only, sel, start, stop, valid, wreg,
		ptr, step, input next_ptr, wrapped);
	modport calc (input active, word_only, sel, start, stop, valid, wreg,
		ptr, step, output next_ptr, wrapped);
endinterface

/* File: pkg/mca_pkg.sv */
/*
 * constants, field layout and types of the circular addressing block.
 * assumes a 32-bit classic wishbone register port and 16-bit pointers.
 */
package mca_pkg;

	localparam int unsigned ADR_W = 8;
	localparam int unsigned PTR_W = 16;
	localparam int unsigned SEL_W = 4;
	localparam int unsigned NUM_AGU = 3;

	// register byte addresses
	localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADR_W-1:0] OFS_XSTART = 8'h04;
	localparam logic [ADR_W-1:0] OFS_XEND   = 8'h08;
	localparam logic [ADR_W-1:0] OFS_YSTART = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_YEND   = 8'h10;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h14;
	localparam logic [ADR_W-1:0] OFS_XLEN   = 8'h18;
	localparam logic [ADR_W-1:0] OFS_YLEN   = 8'h1c;

	// control field positions
	localparam int unsigned CTL_XSEL_LSB = 0;
	localparam int unsigned CTL_YSEL_LSB = 4;
	localparam int unsigned CTL_YEN_BIT  = 14;
	localparam int unsigned CTL_XEN_BIT  = 15;
	localparam logic [SEL_W-1:0] SEL_OFF = 4'hf;

	// status field positions
	localparam int unsigned STAT_XWRAP = 0;
	localparam int unsigned STAT_YWRAP = 1;
	localparam int unsigned STAT_XACT  = 2;
	localparam int unsigned STAT_YACT  = 3;

	// reset values
	localparam logic [PTR_W-1:0] CTRL_RESET  = 16'h00ff;
	localparam logic [PTR_W-1:0] BOUND_RESET = 16'h0000;

	// generator indices
	localparam int unsigned AGU_XR = 0;
	localparam int unsigned AGU_XW = 1;
	localparam int unsigned AGU_Y  = 2;

	// longest buffer in words
	localparam logic [16:0] MAX_LEN_WORDS = 17'h08000;

	typedef logic [PTR_W-1:0] mca_ptr_t;
	typedef logic [SEL_W-1:0] mca_sel_t;
	typedef enum logic {BUS_IDLE, BUS_ACK} mca_bus_st_t;

endpackage

/* File: verif/mca_core_model.sv */
/*
 * core side model: issues pointer updates on any generator lane.
 * assumes a one-cycle done answers every request.
 */
`timescale 1ns/1ns
module mca_core_model
	import mca_pkg::*;
(
	// clock and answers
	input  wire logic                        clk_i,
	input  wire logic [mca_pkg::NUM_AGU-1:0] done_i,
	input  wire logic [mca_pkg::NUM_AGU-1:0] wrapped_i,
	input  wire logic [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] ptr_i,
	// requests
	output logic      [mca_pkg::NUM_AGU-1:0] valid_o,
	output logic      [mca_pkg::NUM_AGU-1:0][mca_pkg::SEL_W-1:0] wreg_o,
	output logic      [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] ptr_o,
	output logic      [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] step_o
);
	initial begin
		valid_o = '0;
		wreg_o = '0;
		ptr_o = '0;
		step_o = '0;
	end
	// idle cycles model a slow core; a released lane shows inverted data
	task automatic issue(input int ln, wr, p, s, idle,
		output logic [15:0] q, output logic w, output logic ok);
		int k;
		repeat (idle) @(posedge clk_i);
		@(posedge clk_i);
		valid_o[ln] <= 1'b1;
		wreg_o[ln] <= wr[3:0];
		ptr_o[ln] <= p[15:0];
		step_o[ln] <= s[15:0];
		@(posedge clk_i);
		valid_o[ln] <= 1'b0;
		ptr_o[ln] <= ~p[15:0];
		step_o[ln] <= ~s[15:0];
		#1;
		for (k = 0; k < 4 && done_i[ln] !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		ok = done_i[ln];
		q = ptr_i[ln];
		w = wrapped_i[ln];
	endtask
endmodule

/* File: verif/mca_top_assertions.sv */
/*
 * port assertions of the circular addressing top.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module mca_top_assertions
	import mca_pkg::*;
(
	// clock and reset
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	// wishbone
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	// generators
	input wire logic [mca_pkg::NUM_AGU-1:0] agu_valid_i,
	input wire logic [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] agu_ptr_i,
	input wire logic [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] agu_step_i,
	input wire logic [mca_pkg::NUM_AGU-1:0] agu_done_o,
	input wire logic [mca_pkg::NUM_AGU-1:0] agu_wrapped_o,
	input wire logic [mca_pkg::NUM_AGU-1:0][mca_pkg::PTR_W-1:0] agu_ptr_o,
	input wire logic                        x_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_xplain; agu_done_o[0] && !agu_wrapped_o[0]; endsequence
	a_ack_one: assert property (s_take |=> wb_ack_o)
		else $error("ack late");
	a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_done_lat: assert property (agu_valid_i[1] |=> agu_done_o[1])
		else $error("done late");
	// a one-edge reset clears the pointer, so skip the edge after it
	a_ptr_hold: assert property (!agu_done_o[1] && !$past(rst_i) |->
		$stable(agu_ptr_o[1])) else $error("pointer moved without done");
	a_y_even: assert property (agu_done_o[2] |-> !agu_ptr_o[2][0])
		else $error("odd y pointer");
	a_x_plain: assert property (s_xplain |-> agu_ptr_o[0] ==
		$past(agu_ptr_i[0]) + $past(agu_step_i[0])) else $error("bad sum");
	a_xw_active: assert property (agu_wrapped_o[1] |-> x_active_o)
		else $error("x wrap while inactive");
	a_wrap_done: assert property ((agu_wrapped_o & ~agu_done_o) == '0)
		else $error("wrap without done");
endmodule
bind mca_top mca_top_assertions mca_top_assertions_inst (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .agu_valid_i, .agu_ptr_i,
	.agu_step_i, .agu_done_o, .agu_wrapped_o, .agu_ptr_o, .x_active_o);

/* File: verif/mca_top_test.sv */
/*
 * self-checking bench of the circular addressing top against a model.
 * assumes the core model drives all generator lanes.
 */
`timescale 1ns/1ns
module mca_top_test;
	import mca_pkg::*;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             wb_cyc_i = 1'b0;
	logic             wb_stb_i = 1'b0;
	logic             wb_we_i = 1'b0;
	logic [7:0]       wb_adr_i = '0;
	logic [3:0]       wb_sel_i = '0;
	logic [31:0]      wb_dat_i = '0;
	logic [31:0]      wb_dat_o;
	logic             wb_ack_o, x_active_o, y_active_o;
	logic [2:0]       agu_valid_i, agu_done_o, agu_wrapped_o;
	logic [2:0][3:0]  agu_wreg_i;
	logic [2:0][15:0] agu_ptr_i, agu_step_i, agu_ptr_o;
	logic [15:0]      rm [5] = '{16'h00ff, 16'h0, 16'h0, 16'h0, 16'h0};
	logic [15:0]      modes [4] = '{16'hc021, 16'hc0ff, 16'h0021, 16'h402f};
	int               num_errors = 0;
	int               checks_done = 0;
	int               cur, seed, p, l;
	logic [1:0]       flg = '0;

	initial forever #20 clk_i = ~clk_i;

	mca_top mca_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .agu_valid_i,
		.agu_wreg_i, .agu_ptr_i, .agu_step_i, .agu_done_o, .agu_wrapped_o,
		.agu_ptr_o, .x_active_o, .y_active_o);
	mca_core_model mca_core_model_inst (.clk_i, .done_i(agu_done_o),
		.wrapped_i(agu_wrapped_o), .ptr_i(agu_ptr_o), .valid_o(agu_valid_i),
		.wreg_o(agu_wreg_i), .ptr_o(agu_ptr_i), .step_o(agu_step_i));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] sl, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sl;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			num_errors++;
			give_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] sl);
		logic [31:0] q;
		wb(1'b1, a, {16'h0, d}, sl, q);
		if (a <= OFS_YEND && a[1:0] == 2'b00) begin
			if (sl[0])
				rm[a >> 2][7:0] = d[7:0];
			if (sl[1])
				rm[a >> 2][15:8] = d[15:8];
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, 4'hf, q);
		chk(q, e);
	endtask

	// status as the rules predict it: sticky wraps and decoded activity
	task automatic rds();
		logic xa, ya;
		xa = rm[0][15] && rm[0][3:0] != 4'hf;
		ya = rm[0][14] && rm[0][7:4] != 4'hf;
		rdc(OFS_STATUS, {28'h0, ya, xa, flg});
	endtask

	// reference wrap: end checked for steps of zero or more, start for negative steps, y lane stays even
	function automatic logic [16:0] ref_next(int ln, wr, p, s);
		int st, en, n, r;
		logic hit, w;
		logic [3:0] sl;
		sl = (ln < 2) ? rm[0][3:0] : rm[0][7:4];
		hit = rm[0][(ln < 2) ? 15 : 14] && sl != 4'hf && wr == sl;
		st = (ln < 2) ? rm[1] : rm[3];
		en = (ln < 2) ? rm[2] : rm[4];
		n = p + s;
		r = n & 'hffff;
		w = hit && ((s >= 0 && p <= en && n > en) || (s < 0 && p >= st && n < st));
		if (w)
			r = (s >= 0) ? st : en;
		if (ln == 2)
			r = r & 'hfffe;
		return {w, r[15:0]};
	endfunction

	task automatic run(input int ln, wr, p, s);
		logic [16:0] e;
		logic [15:0] q;
		logic w, ok;
		e = ref_next(ln, wr, p, s);
		mca_core_model_inst.issue(ln, wr, p, s, $urandom_range(0, 2), q, w, ok);
		if (ok !== 1'b1) begin
			num_errors++;
			give_verdict();
		end
		chk(q, e[15:0]);
		chk(w, e[16]);
		if (e[16])
			flg[ln == 2] = 1'b1;
		cur = q;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = $urandom(82);
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(OFS_CTRL, 32'h00ff);
		rdc(OFS_YEND, 32'h0);
		wr(8'h20, 16'h1234, 4'hf);
		rdc(8'h20, 32'h0);
		wr(OFS_XSTART, 16'h1100, 4'hf);
		wr(OFS_XEND, 16'h1163, 4'hf);
		wr(OFS_CTRL, 16'h8001, 4'hf);
		rdc(OFS_XEND, 32'h1163);
		rdc(OFS_XLEN, 32'h0032);
		cur = 'h1110;
		repeat (60) run(1, 1, cur, 2);
		chk(x_active_o, 1'b1);
		rds();
		wr(OFS_XEND, 16'h117f, 4'hf);
		wr(OFS_YSTART, 16'h2000, 4'hf);
		wr(OFS_YEND, 16'h201f, 4'hf);
		rdc(OFS_YLEN, 32'h0010);
		foreach (modes[m]) begin
			wr(OFS_CTRL, modes[m], 4'hf);
			repeat (40) begin
				l = $urandom_range(0, 2);
				p = (l < 2) ? 'h10f8 + $urandom_range(0, 'h90) :
					'h1ff8 + $urandom_range(0, 'h30);
				run(l, $urandom_range(1, 3), p, $urandom_range(0, 8) * 2 - 8);
			end
			chk(x_active_o, modes[m][15] && modes[m][3:0] != 4'hf);
			chk(y_active_o, modes[m][14] && modes[m][7:4] != 4'hf);
			rds();
			wr(OFS_STATUS, 16'h0003, 4'h1);
			flg = '0;
			rds();
		end
		wr(OFS_XSTART, 16'h0, 4'hf);
		wr(OFS_XEND, 16'hffff, 4'hf);
		rdc(OFS_XLEN, 32'h8000);
		wr(OFS_YSTART, 16'habcd, 4'h1);
		rdc(OFS_YSTART, {16'h0, rm[3]});
		wr(OFS_YSTART, 16'h55ee, 4'h2);
		rdc(OFS_YSTART, {16'h0, rm[3]});
		// a second reset in mid-run must restore the control, x end, status and pointer reset values
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rm = '{16'h00ff, 16'h0, 16'h0, 16'h0, 16'h0};
		flg = '0;
		chk({31'h0, |agu_ptr_o}, 32'h0);
		chk(x_active_o, 1'b0);
		rdc(OFS_CTRL, 32'h00ff);
		rdc(OFS_XEND, 32'h0);
		rds();
		give_verdict();
	end

	initial begin
		repeat (50000) @(posedge clk_i);
		num_errors++;
		give_verdict();
	end
endmodule
